// File: spsc_control.sv
// What this block does
// - Divider powered when any output selects it or output B selects SYSREF.
// - Drive codes 32-47 alias codes 16-31.
// - Chip enable pin or bit powers down.
// - Sync request reclocked to reference rising edge.
// - Phase ready after calibration if enabled, loop, reset delay if fractional.
// - Included divide is 1, 6 or 4.
// - Software bit rise, or pin rise with calibration enable, syncs.
// - First setting of align mode is not sync.
// - Pin toggle calibrates only with calibration enable.
// - Sync or modulator reset zeroes phase; seeds add.
// - Phase shift scales by included divide over divide.
// - Seeds need order above zero; order one multiples.
// - Divide codes 0-17 valid, 18-31 invalid.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module spsc_control
  import spsc_pkg::*;
#(
  parameter int CAL_COUNT = CAL_CYCLES,
  parameter int LOOP_COUNT = LOOP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [31:0] rdata_o,
  input wire logic sync_pin_i,
  input wire logic chip_enable_i,
  input wire logic reference_input_i,
  output logic divider_power_o,
  output logic [5:0] drive_level_a_o,
  output logic [5:0] drive_level_b_o,
  output logic powered_down_o,
  output logic calibration_start_o,
  output logic sync_o,
  output logic phase_ready_o,
  output logic [2:0] included_divide_o,
  output logic [9:0] divide_value_o,
  output logic [31:0] phase_offset_o
);
  function automatic logic [9:0] div_value(input logic [4:0] code);
    case (code)
      5'h00: div_value = 10'h002;
      5'h01: div_value = 10'h004;
      5'h02: div_value = 10'h006;
      5'h03: div_value = 10'h008;
      5'h04: div_value = 10'h00c;
      5'h05: div_value = 10'h010;
      5'h06: div_value = 10'h018;
      5'h07: div_value = 10'h020;
      5'h08: div_value = 10'h030;
      5'h09: div_value = 10'h040;
      5'h0a: div_value = 10'h048;
      5'h0b: div_value = 10'h060;
      5'h0c: div_value = 10'h080;
      5'h0d: div_value = 10'h0c0;
      5'h0e: div_value = 10'h100;
      5'h0f: div_value = 10'h180;
      5'h10: div_value = 10'h200;
      5'h11: div_value = 10'h300;
      default: div_value = 10'h000;
    endcase
  endfunction

  // Divisible by three, excluding 24 and 192.
  function automatic logic div_by_three(input logic [4:0] code);
    case (code)
      5'h02, 5'h04, 5'h08, 5'h0a, 5'h0b, 5'h0f, 5'h11: div_by_three = 1'b1;
      default: div_by_three = 1'b0;
    endcase
  endfunction

  function automatic logic [5:0] eff_level(input logic [5:0] code);
    if (code >= LVL_ALIAS_LO && code <= LVL_ALIAS_HI) begin
      eff_level = code - LVL_ALIAS_OFS;
    end else begin
      eff_level = code;
    end
  endfunction

  logic cal_en;
  logic pd_bit;
  logic align_mode;
  logic pin_mask;
  logic mod_rst_n;
  logic align_armed;
  logic [1:0] src_a;
  logic [1:0] src_b;
  logic [5:0] lvl_a;
  logic [5:0] lvl_b;
  logic [4:0] div_code;
  logic div_pd;
  logic [31:0] den;
  logic [31:0] num;
  logic [2:0] order;
  logic [15:0] mrst_cnt;
  logic [31:0] phase_acc;
  logic pend_sync;
  logic pend_cal;
  logic recal_needed;
  logic synced;
  logic pd_q;
  logic [15:0] cnt;
  spsc_state_type state;
  spsc_state_type next_state;
  logic [15:0] next_cnt;

  logic ce_level;
  logic pin_rise;
  logic pin_change;
  logic ref_rise;

  spsc_pin_sync u_sync_pin (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(sync_pin_i),
    .level_o(),
    .rise_o(pin_rise),
    .change_o(pin_change)
  );

  spsc_pin_sync u_ce_pin (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(chip_enable_i),
    .level_o(ce_level),
    .rise_o(),
    .change_o()
  );

  spsc_pin_sync u_ref_pin (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(reference_input_i),
    .level_o(),
    .rise_o(ref_rise),
    .change_o()
  );

  wire wr_ctrl = write_i && (addr_i == OFF_CTRL);
  wire wr_out = write_i && (addr_i == OFF_OUTCFG);
  wire wr_den = write_i && (addr_i == OFF_DEN);
  wire wr_num = write_i && (addr_i == OFF_NUM);
  wire wr_seed = write_i && (addr_i == OFF_SEED);
  wire wr_mod = write_i && (addr_i == OFF_MODCFG);

  wire powered_down = pd_bit || !ce_level;
  wire div_valid = (div_code <= DIV_CODE_MAX);
  wire div_needed = (src_a == SRC_DIVIDER) || (src_b == SRC_DIVIDER) ||
                    (src_b == SRC_SYSREF);
  wire both_vco = (src_a == SRC_VCO) && (src_b == SRC_VCO);
  wire [2:0] incl_div = (!align_mode || both_vco) ? 3'h1 :
                        div_by_three(div_code) ? 3'h6 : 3'h4;

  // The first setting of align mode arms it; only later rises sync.
  wire sw_sync = wr_ctrl && wdata_i[CTRL_ALIGN] && !align_mode &&
                 align_armed;
  wire pin_ok = !pin_mask && cal_en && !powered_down;
  wire pin_sync = pin_rise && pin_ok && align_mode;
  wire pin_cal = pin_change && pin_ok;
  wire act = ref_rise && (pend_sync || pend_cal);
  wire act_sync = ref_rise && pend_sync;

  wire reg0_cal = wr_ctrl && wdata_i[CTRL_CAL_EN] && !wdata_i[CTRL_PD] &&
                  ce_level;
  wire start_cal = reg0_cal || (act && cal_en);
  wire start_settle = act_sync && !cal_en;

  // A seed is a multiple of the denominator only for order one.
  wire seed_multiple = (den != 32'h0) && ((wdata_i % den) == 32'h0);
  wire seed_takes = (order != 3'h0) &&
                    ((order != 3'h1) || seed_multiple);
  wire phase_clear = act_sync || !mod_rst_n;
  wire frac_mode = (num != 32'h0);
  wire settling = (state != SPSC_IDLE);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      SPSC_IDLE: begin
        next_state = SPSC_IDLE;
      end
      SPSC_CAL: begin
        if (cnt == 16'h0) begin
          next_state = SPSC_LOOP;
          next_cnt = 16'(LOOP_COUNT - 1);
        end else begin
          next_cnt = cnt - 16'h1;
        end
      end
      SPSC_LOOP: begin
        if (cnt != 16'h0) begin
          next_cnt = cnt - 16'h1;
        end else if (frac_mode && mrst_cnt != 16'h0) begin
          next_state = SPSC_MRST;
          next_cnt = mrst_cnt - 16'h1;
        end else begin
          next_state = SPSC_IDLE;
        end
      end
      SPSC_MRST: begin
        if (cnt == 16'h0) begin
          next_state = SPSC_IDLE;
        end else begin
          next_cnt = cnt - 16'h1;
        end
      end
      default: begin
        next_state = SPSC_IDLE;
        next_cnt = 16'h0;
      end
    endcase
    if (powered_down) begin
      next_state = SPSC_IDLE;
      next_cnt = 16'h0;
    end else if (start_cal) begin
      next_state = SPSC_CAL;
      next_cnt = 16'(CAL_COUNT - 1);
    end else if (start_settle) begin
      next_state = SPSC_LOOP;
      next_cnt = 16'(LOOP_COUNT - 1);
    end
  end

  wire settle_done = settling && (next_state == SPSC_IDLE) && synced;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= SPSC_IDLE;
      cnt <= 16'h0;
      synced <= 1'b0;
      phase_ready_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (powered_down) begin
        synced <= 1'b0;
        phase_ready_o <= 1'b0;
      end else if (act_sync) begin
        synced <= 1'b1;
        phase_ready_o <= 1'b0;
      end else if (settle_done) begin
        phase_ready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pend_sync <= 1'b0;
      pend_cal <= 1'b0;
    end else begin
      // A new request in the acting cycle waits for the next edge.
      pend_sync <= sw_sync || pin_sync || (pend_sync && !ref_rise);
      pend_cal <= pin_cal || (pend_cal && !ref_rise);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      {mod_rst_n, pin_mask, align_mode, pd_bit, cal_en} <= CTRL_RESET;
      align_armed <= 1'b0;
    end else if (wr_ctrl) begin
      cal_en <= wdata_i[CTRL_CAL_EN];
      pd_bit <= wdata_i[CTRL_PD];
      align_mode <= wdata_i[CTRL_ALIGN];
      pin_mask <= wdata_i[CTRL_PIN_MASK];
      mod_rst_n <= wdata_i[CTRL_MOD_RST_N];
      align_armed <= align_armed || wdata_i[CTRL_ALIGN];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      {div_pd, div_code, lvl_b, lvl_a, src_b, src_a} <= OUTCFG_RESET;
    end else if (wr_out) begin
      {div_pd, div_code, lvl_b, lvl_a, src_b, src_a} <= wdata_i[21:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      den <= DEN_RESET;
      num <= 32'h0;
      order <= 3'h0;
      mrst_cnt <= 16'h0;
    end else begin
      if (wr_den) begin
        den <= wdata_i;
      end
      if (wr_num) begin
        num <= wdata_i;
      end
      if (wr_mod) begin
        order <= wdata_i[MOD_ORDER_LSB +: 3];
        mrst_cnt <= wdata_i[MOD_RSTCNT_LSB +: 16];
      end
    end
  end

  // Phase is counted in seed units; degrees follow from the outputs.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      phase_acc <= 32'h0;
    end else if (phase_clear) begin
      phase_acc <= 32'h0;
    end else if (wr_seed && seed_takes) begin
      phase_acc <= phase_acc + wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pd_q <= 1'b1;
      recal_needed <= 1'b0;
    end else begin
      pd_q <= powered_down;
      // Leaving power-down wins over a same-cycle register zero write.
      if (pd_q && !powered_down) begin
        recal_needed <= 1'b1;
      end else if (reg0_cal) begin
        recal_needed <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      divider_power_o <= 1'b0;
      drive_level_a_o <= 6'h0;
      drive_level_b_o <= 6'h0;
      powered_down_o <= 1'b1;
      calibration_start_o <= 1'b0;
      sync_o <= 1'b0;
      included_divide_o <= 3'h1;
      divide_value_o <= 10'h0;
      phase_offset_o <= 32'h0;
    end else begin
      divider_power_o <= div_needed && !powered_down;
      drive_level_a_o <= eff_level(lvl_a);
      drive_level_b_o <= eff_level(lvl_b);
      powered_down_o <= powered_down;
      calibration_start_o <= start_cal && !powered_down;
      sync_o <= act_sync;
      included_divide_o <= incl_div;
      divide_value_o <= div_value(div_code);
      phase_offset_o <= phase_acc;
    end
  end

  wire [31:0] status_word = {6'h0, div_value(div_code), 5'h0, incl_div,
                             1'b0, div_valid, recal_needed,
                             divider_power_o, phase_ready_o,
                             state[2] || state[3], state[1], powered_down};

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0;
    end else if (read_i) begin
      case (addr_i)
        OFF_CTRL: rdata_o <= {27'h0, mod_rst_n, pin_mask, align_mode,
                              pd_bit, cal_en};
        OFF_OUTCFG: rdata_o <= {10'h0, div_pd, div_code, lvl_b, lvl_a,
                                src_b, src_a};
        OFF_DEN: rdata_o <= den;
        OFF_NUM: rdata_o <= num;
        OFF_MODCFG: rdata_o <= {mrst_cnt, 13'h0, order};
        OFF_STATUS: rdata_o <= status_word;
        OFF_PHASE: rdata_o <= phase_acc;
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end
endmodule // spsc_control

// File: spsc_control_checker.sv
module spsc_control_checker
  import spsc_pkg::*;
#(
  parameter int CAL_COUNT = CAL_CYCLES,
  parameter int LOOP_COUNT = LOOP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [31:0] rdata_o,
  input wire logic reference_input_i,
  input wire logic divider_power_o,
  input wire logic [5:0] drive_level_a_o,
  input wire logic powered_down_o,
  input wire logic calibration_start_o,
  input wire logic sync_o,
  input wire logic phase_ready_o,
  input wire logic [2:0] included_divide_o,
  input wire logic [31:0] phase_offset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  logic ref_q;
  logic [7:0] since_rise;
  logic [15:0] since_sync;
  wire logic out_wr = write_i && addr_i == OFF_OUTCFG;
  wire logic ctl_wr = write_i && addr_i == OFF_CTRL;
  wire logic ref_rise = reference_input_i && !ref_q;
  function automatic logic [5:0] fix_level(input logic [5:0] l);
    return (l >= LVL_ALIAS_LO && l <= LVL_ALIAS_HI) ? l - LVL_ALIAS_OFS : l;
  endfunction
  function automatic logic uses_div(input logic [31:0] w);
    return w[1:0] == SRC_DIVIDER || w[3:2] == SRC_DIVIDER ||
      w[3:2] == SRC_SYSREF;
  endfunction
  // Cycle counts since the last raw reference rise and the last sync pulse.
  always_ff @(posedge clock_i) begin
    ref_q <= reference_input_i;
    if (!rst_n_i) since_rise <= 8'hff;
    else if (ref_rise) since_rise <= 8'h0;
    else if (since_rise != 8'hff) since_rise <= since_rise + 8'h1;
    if (!rst_n_i || sync_o) since_sync <= 16'h0;
    else if (since_sync != 16'hffff) since_sync <= since_sync + 16'h1;
  end
  div_power_a: assert property (out_wr |-> ##3
    divider_power_o == (uses_div($past(wdata_i, 3)) && !powered_down_o))
    else $error("divider power wrong");
  level_remap_a: assert property (out_wr |-> ##3
    drive_level_a_o == fix_level($past(wdata_i[9:4], 3)))
    else $error("drive level wrong");
  incl_one_a: assert property (out_wr && wdata_i[3:0] == 4'h5
    |-> ##3 included_divide_o == 3'h1) else $error("included not one");
  pd_bit_a: assert property (ctl_wr && wdata_i[CTRL_PD]
    |-> ##3 powered_down_o) else $error("power down ignored");
  cal_start_a: assert property (ctl_wr && wdata_i[CTRL_CAL_EN] &&
    !wdata_i[CTRL_PD] && !powered_down_o |=> calibration_start_o)
    else $error("no calibration start");
  sync_pulse_a: assert property (sync_o |=> !sync_o)
    else $error("sync pulse too long");
  cal_pulse_a: assert property (calibration_start_o |=>
    !calibration_start_o) else $error("calibration pulse too long");
  sync_reclock_a: assert property (sync_o |-> since_rise >= 8'h2 &&
    since_rise <= 8'h7) else $error("sync not on reference rise");
  phase_clear_a: assert property (sync_o |-> ##[1:2]
    phase_offset_o == 32'h0) else $error("phase not cleared");
  settle_time_a: assert property ($rose(phase_ready_o) |->
    since_sync >= 16'(LOOP_COUNT - 1)) else $error("ready too early");
  rdata_idle_a: assert property (!read_i |=> rdata_o == 32'h0)
    else $error("read data not idle");
  cover property (sync_o);
  cover property ($rose(phase_ready_o));
  cover property (calibration_start_o);
endmodule // spsc_control_checker

bind spsc_control spsc_control_checker #(.CAL_COUNT(CAL_COUNT),
  .LOOP_COUNT(LOOP_COUNT)) chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
  .rdata_o(rdata_o), .reference_input_i(reference_input_i),
  .divider_power_o(divider_power_o), .drive_level_a_o(drive_level_a_o),
  .powered_down_o(powered_down_o), .calibration_start_o(calibration_start_o),
  .sync_o(sync_o), .phase_ready_o(phase_ready_o),
  .included_divide_o(included_divide_o), .phase_offset_o(phase_offset_o));

// File: spsc_host_model.sv
module spsc_host_model (
  input wire logic pin_level_i,
  output logic reference_input_o,
  output logic sync_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reference_input_o = 1'b0;
    #3;
    forever #65 reference_input_o = ~reference_input_o;
  end
  // The pin only moves just after a falling reference edge, far from rises.
  initial begin
    sync_pin_o = 1'b0;
    forever @(negedge reference_input_o) sync_pin_o <= pin_level_i;
  end
endmodule // spsc_host_model

// File: spsc_pin_sync.sv
module spsc_pin_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic change_o
);
  logic s1;
  logic s2;
  logic s3;
  logic stable;

  // A change is taken only once the second and third stages agree.
  assign stable = (s2 == s3);
  assign change_o = stable && (s3 != level_o);
  assign rise_o = change_o && s3;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (stable) begin
        level_o <= s3;
      end
    end
  end
endmodule // spsc_pin_sync

// File: spsc_pkg.sv
package spsc_pkg;
  // Register byte addresses on the plain register port.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OUTCFG = 8'h04;
  localparam logic [7:0] OFF_DEN = 8'h08;
  localparam logic [7:0] OFF_NUM = 8'h0c;
  localparam logic [7:0] OFF_SEED = 8'h10;
  localparam logic [7:0] OFF_MODCFG = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_PHASE = 8'h1c;

  // Control register (register zero) bit positions.
  localparam int CTRL_CAL_EN = 0;
  localparam int CTRL_PD = 1;
  localparam int CTRL_ALIGN = 2;
  localparam int CTRL_PIN_MASK = 3;
  localparam int CTRL_MOD_RST_N = 4;
  localparam logic [4:0] CTRL_RESET = 5'h18;

  // Output configuration field positions.
  localparam int OUT_SRC_A_LSB = 0;
  localparam int OUT_SRC_B_LSB = 2;
  localparam int OUT_LVL_A_LSB = 4;
  localparam int OUT_LVL_B_LSB = 10;
  localparam int OUT_DIV_LSB = 16;
  localparam int OUT_DIV_PD = 21;
  localparam logic [21:0] OUTCFG_RESET = 22'h000114;

  // Modulator configuration field positions.
  localparam int MOD_ORDER_LSB = 0;
  localparam int MOD_RSTCNT_LSB = 16;

  // Output source select encodings.
  localparam logic [1:0] SRC_DIVIDER = 2'h0;
  localparam logic [1:0] SRC_VCO = 2'h1;
  localparam logic [1:0] SRC_SYSREF = 2'h2;

  // Drive level remap window.
  localparam logic [5:0] LVL_ALIAS_LO = 6'h20;
  localparam logic [5:0] LVL_ALIAS_HI = 6'h2f;
  localparam logic [5:0] LVL_ALIAS_OFS = 6'h10;

  localparam logic [4:0] DIV_CODE_MAX = 5'h11;
  localparam logic [31:0] DEN_RESET = 32'h00000001;

  // Status register bit positions.
  localparam int ST_PD = 0;
  localparam int ST_CAL = 1;
  localparam int ST_SETTLE = 2;
  localparam int ST_READY = 3;
  localparam int ST_DIVPWR = 4;
  localparam int ST_RECAL = 5;
  localparam int ST_DIVOK = 6;
  localparam int ST_INCL_LSB = 8;
  localparam int ST_DIVVAL_LSB = 16;

  // Settling times and their cycle counts at the 100 MHz clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 10000;
  localparam int LOOP_SETTLE_NS = 10000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOOP_CYCLES =
    (LOOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SPSC_IDLE = 4'b0001,
    SPSC_CAL = 4'b0010,
    SPSC_LOOP = 4'b0100,
    SPSC_MRST = 4'b1000
  } spsc_state_type;
endpackage

// File: synth_phase_sync_control_test.sv
module synth_phase_sync_control_test;
  import spsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] DIVS [0:17] = '{10'h2, 10'h4, 10'h6, 10'h8, 10'hc,
    10'h10, 10'h18, 10'h20, 10'h30, 10'h40, 10'h48, 10'h60, 10'h80, 10'hc0,
    10'h100, 10'h180, 10'h200, 10'h300};
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic chip_enable_i = 1'b1;
  logic pin_level = 1'b0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic sync_pin_i, reference_input_i, divider_power_o, powered_down_o;
  logic calibration_start_o, sync_o, phase_ready_o;
  logic [5:0] drive_level_a_o, drive_level_b_o;
  logic [2:0] included_divide_o;
  logic [9:0] divide_value_o;
  logic [31:0] rdata_o, phase_offset_o, v, s1, s2;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_sync, n_cal, t_sync, t_rdy;
  int cycles = 0;
  integer seed = 10;
  spsc_host_model host_u (.pin_level_i(pin_level),
    .reference_input_o(reference_input_i), .sync_pin_o(sync_pin_i));
  spsc_control #(.CAL_COUNT(4), .LOOP_COUNT(4)) dut_u (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .sync_pin_i(sync_pin_i), .chip_enable_i(chip_enable_i),
    .reference_input_i(reference_input_i),
    .divider_power_o(divider_power_o), .drive_level_a_o(drive_level_a_o),
    .drive_level_b_o(drive_level_b_o), .powered_down_o(powered_down_o),
    .calibration_start_o(calibration_start_o), .sync_o(sync_o),
    .phase_ready_o(phase_ready_o), .included_divide_o(included_divide_o),
    .divide_value_o(divide_value_o), .phase_offset_o(phase_offset_o));
  initial forever #5 clock_i = ~clock_i;
  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask
  task automatic watch(input int n);
    n_sync = 0;
    n_cal = 0;
    t_sync = -1;
    t_rdy = -1;
    for (int k = 0; k < n; k++) begin
      @(posedge clock_i);
      if (sync_o === 1'b1) begin
        n_sync++;
        t_sync = k;
      end
      if (phase_ready_o === 1'b1 && t_rdy < 0) t_rdy = k;
      if (calibration_start_o === 1'b1) n_cal++;
    end
  endtask
  task automatic pin_case(input logic [31:0] ctrl, input int es, int ec);
    wr(OFF_CTRL, ctrl);
    cyc(30);
    pin_level <= 1'b1;
    watch(60);
    check(32'(n_sync), 32'(es));
    check(32'(n_cal), 32'(ec));
    pin_level <= 1'b0;
    watch(60);
    check(32'(n_cal), 32'(ec));
    check(32'(n_sync), 32'h0);
  endtask
  function automatic logic [9:0] div_of(input logic [4:0] c);
    return c < 5'h12 ? DIVS[c] : 10'h0;
  endfunction
  function automatic logic [2:0] incl_of(input logic [31:0] w);
    logic [9:0] d;
    d = div_of(w[20:16]);
    if (w[3:0] == 4'h5) return 3'h1;
    if (d != 0 && d % 3 == 0 && d != 10'h18 && d != 10'hc0) return 3'h6;
    return 3'h4;
  endfunction
  function automatic logic [5:0] lvl_of(input logic [5:0] l);
    return (l >= 6'h20 && l <= 6'h2f) ? l - 6'h10 : l;
  endfunction
  initial begin
    cyc(3);
    rst_n_i <= 1'b1;
    #1 check(32'(powered_down_o), 32'h1);
    rd(OFF_CTRL, 32'h18);
    rd(8'hfc, 32'h0);
    cyc(6);
    check(32'(powered_down_o), 32'h0);
    wr(OFF_CTRL, 32'h1c);
    watch(30);
    check(32'(n_sync), 32'h0);
    for (int i = 0; i < 36; i++) begin
      v = $random(seed);
      v[1:0] = 2'(i % 3);
      v[3:2] = 2'((i / 3) % 3);
      if (i == 0) v[20:16] = 5'h6;
      if (i == 1) v[20:16] = 5'hd;
      wr(OFF_OUTCFG, v);
      cyc(3);
      check(32'(divider_power_o), 32'(v[1:0] == 0 || v[3:2] != 1));
      check(32'(drive_level_a_o), 32'(lvl_of(v[9:4])));
      check(32'(drive_level_b_o), 32'(lvl_of(v[15:10])));
      check(32'(divide_value_o), 32'(div_of(v[20:16])));
      check(32'(included_divide_o), 32'(incl_of(v)));
    end
    wr(OFF_CTRL, 32'h1e);
    cyc(3);
    check(32'(powered_down_o), 32'h1);
    wr(OFF_CTRL, 32'h1c);
    cyc(3);
    check(32'(powered_down_o), 32'h0);
    chip_enable_i <= 1'b0;
    cyc(8);
    check(32'(powered_down_o), 32'h1);
    chip_enable_i <= 1'b1;
    cyc(8);
    check(32'(powered_down_o), 32'h0);
    wr(OFF_CTRL, 32'h1d);
    watch(4);
    check(32'(n_cal), 32'h1);
    wr(OFF_DEN, 32'h1000);
    wr(OFF_MODCFG, 32'h2);
    s1 = $random(seed) & 32'h7ff;
    s2 = $random(seed) & 32'h7ff;
    wr(OFF_SEED, s1);
    wr(OFF_SEED, s2);
    cyc(3);
    check(phase_offset_o, s1 + s2);
    wr(OFF_MODCFG, 32'h1);
    wr(OFF_SEED, 32'h5);
    wr(OFF_MODCFG, 32'h0);
    wr(OFF_SEED, 32'h7);
    cyc(3);
    check(phase_offset_o, s1 + s2);
    wr(OFF_NUM, 32'h100);
    wr(OFF_MODCFG, 32'h00080002);
    wr(OFF_CTRL, 32'h18);
    cyc(3);
    check(32'(included_divide_o), 32'h1);
    wr(OFF_CTRL, 32'h1c);
    watch(40);
    check(32'(n_sync), 32'h1);
    check(32'(t_rdy - t_sync), 32'(4 + 8));
    check(32'(n_cal), 32'h0);
    check(phase_offset_o, 32'h0);
    check(32'(phase_ready_o), 32'h1);
    pin_case(32'h15, 1, 1);
    pin_case(32'h14, 0, 0);
    pin_case(32'h1d, 0, 0);
    wr(OFF_OUTCFG, 32'h5);
    cyc(3);
    check(32'(divider_power_o), 32'h0);
    wr(OFF_SEED, s1);
    cyc(3);
    check(phase_offset_o, s1);
    wr(OFF_CTRL, 32'h0c);
    cyc(3);
    check(phase_offset_o, 32'h0);
    tally_and_finish();
  end
endmodule // synth_phase_sync_control_test
